// ---- include/vpt_pkg.sv ----
package vpt_pkg;

  // ----------------------------------------------------------------
  // trace geometry
  // ----------------------------------------------------------------
  localparam int unsigned CODE_W        = 10;
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned TRACE_POINTS  = 1001;
  localparam int unsigned SEGS_PER_SPAN = 1000;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 10'h3E8;

  // ----------------------------------------------------------------
  // display-unit scaling
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] TOP_LINE_CODE = 10'h3E8;
  localparam logic [CODE_W-1:0] DU_PER_DIV    = 10'h064;
  localparam int unsigned       OVERRANGE_DU  = 23;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned MANUAL_SAMPLE_NS = 200000;
  localparam int unsigned REFRESH_NS       = 17000000;
  localparam int unsigned MANUAL_CYCLES_DEF  = MANUAL_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_CYCLES_DEF = REFRESH_NS / CLK_PERIOD_NS;
  localparam logic [32:0] SEG_ACC_STEP = 33'h0000003E8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACQ_IDLE   = 3'b001,
    ACQ_SWEEP  = 3'b010,
    ACQ_MANUAL = 3'b100
  } vpt_acq_t;

  localparam vpt_acq_t ACQ_RST = ACQ_IDLE;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [CODE_W-1:0] data;
    logic              over;
    logic [3:0]        div;
  } vpt_disp_t;

  typedef struct packed {
    logic              valid;
    logic [CODE_W-1:0] code;
  } vpt_sample_t;

endpackage : vpt_pkg

// ---- core/vpt_peak_hold.sv ----
`timescale 1ns/10ps
module vpt_peak_hold
  import vpt_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire vpt_sample_t       SAMPLE,
  input  wire logic              CLEAR,
  output logic [CODE_W-1:0]      PEAK
);

  typedef struct packed {
    logic [CODE_W-1:0] peak;
  } vpt_ph_state_t;

  vpt_ph_state_t q;
  vpt_ph_state_t d;

  // ----------------------------------------------------------------
  // positive peak hold
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (CLEAR) begin
      d.peak = SAMPLE.valid ? SAMPLE.code : '0;
    end else if (SAMPLE.valid && (SAMPLE.code > q.peak)) begin // RL12 RL4
      d.peak = SAMPLE.code;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign PEAK = q.peak;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  peak_grows_a: assert property ( // RL12
    (!CLEAR && SAMPLE.valid && SAMPLE.code > PEAK) |=> PEAK == $past(SAMPLE.code, 1))
    else $error("peak did not take a larger sample");
  peak_holds_a: assert property ( // RL4
    (!CLEAR && !(SAMPLE.valid && SAMPLE.code > PEAK)) |=> $stable(PEAK))
    else $error("peak changed without a larger sample");

endmodule : vpt_peak_hold

// ---- core/vpt_sampler.sv ----
// What this block does
// [RL1] store points as unsigned 10-bit codes
// [RL2] codes above 1000 flag overrange band
// [RL3] one division spans 100 display units
// [RL4] store segment peak, not instantaneous sample
// [RL5] segment runs from point to next point
// [RL6] segment lasts sweep time over 1000
// [RL7] 1001 segments, last one past stop
// [RL8] manual: rewrite point every 200 us
// [RL9] manual address changes once per refresh
// [RL10] readout scans 1001 addresses per refresh
// [RL11] write peak, clear, advance address
// [RL12] replace peak only on strictly greater
`timescale 1ns/10ps
module vpt_sampler
  import vpt_pkg::*;
#(
  parameter int unsigned MANUAL_CYCLES  = MANUAL_CYCLES_DEF,
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYCLES_DEF
)
(
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire vpt_sample_t       SAMPLE,
  input  wire logic              SWEEP_START,
  input  wire logic [31:0]       SWEEP_TIME_CYCLES,
  input  wire logic              MANUAL_MODE,
  input  wire logic [ADDR_W-1:0] MANUAL_ADDR,
  output logic                   SWEEP_BUSY,
  output logic                   SWEEP_DONE,
  output logic [ADDR_W-1:0]      SWEEP_ADDR,
  output vpt_disp_t              DISP
);

  typedef struct packed {
    vpt_acq_t                              acq;
    logic [32:0]                           acc;
    logic [ADDR_W-1:0]                     seg_addr;
    logic                                  done;
    logic [31:0]                           man_cnt;
    logic [ADDR_W-1:0]                     man_addr;
    logic [31:0]                           ref_cnt;
    logic                                  rd_active;
    logic [ADDR_W-1:0]                     rd_addr;
    vpt_disp_t                             disp;
    logic [TRACE_POINTS-1:0][CODE_W-1:0]   mem;
  } vpt_state_t;

  vpt_state_t        q;
  vpt_state_t        d;
  logic [32:0]       acc_sum;
  logic [32:0]       span;
  logic              seg_tick;
  logic              man_tick;
  logic              ref_tick;
  logic              start_sweep;
  logic              enter_manual;
  logic              peak_clear;
  logic [CODE_W-1:0] peak;

  function automatic logic [3:0] vpt_div(input logic [CODE_W-1:0] code);
    logic [CODE_W-1:0] quo;
    quo = code / DU_PER_DIV;
    return quo[3:0];
  endfunction : vpt_div

  // ----------------------------------------------------------------
  // segment timing: fractional divider of sweep time by 1000
  // ----------------------------------------------------------------
  assign span = (SWEEP_TIME_CYCLES < SEGS_PER_SPAN) ? {1'b0, 32'(SEGS_PER_SPAN)}
                                                    : {1'b0, SWEEP_TIME_CYCLES};
  assign acc_sum      = q.acc + SEG_ACC_STEP;
  assign seg_tick     = (q.acq == ACQ_SWEEP) && (acc_sum >= span); // RL6
  assign man_tick     = (q.acq == ACQ_MANUAL) && (q.man_cnt == 32'(MANUAL_CYCLES - 1)); // RL8
  assign ref_tick     = (q.ref_cnt == 32'(REFRESH_CYCLES - 1));
  assign start_sweep  = SWEEP_START && !MANUAL_MODE;
  assign enter_manual = MANUAL_MODE && (q.acq != ACQ_MANUAL);
  assign peak_clear   = seg_tick || man_tick || start_sweep || enter_manual; // RL11 RL8

  vpt_peak_hold vpt_peak_hold_i (
    .CLOCK (CLOCK),
    .RST   (RST),
    .SAMPLE(SAMPLE),
    .CLEAR (peak_clear),
    .PEAK  (peak)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.done       = 1'b0;
    d.disp.valid = 1'b0;
    unique case (q.acq)
      ACQ_IDLE: begin
        if (enter_manual) begin
          d.acq     = ACQ_MANUAL;
          d.man_cnt = '0;
        end else if (start_sweep) begin
          d.acq      = ACQ_SWEEP;
          d.acc      = '0;
          d.seg_addr = '0;
        end
      end
      ACQ_SWEEP: begin
        if (enter_manual) begin
          d.acq     = ACQ_MANUAL;
          d.man_cnt = '0;
        end else if (start_sweep) begin
          d.acc      = '0;
          d.seg_addr = '0;
        end else if (seg_tick) begin
          d.acc              = acc_sum - span;
          d.mem[q.seg_addr]  = peak; // RL4 RL5 RL11 RL1
          if (q.seg_addr == LAST_ADDR) begin // RL7
            d.acq  = ACQ_IDLE;
            d.done = 1'b1;
          end else begin
            d.seg_addr = q.seg_addr + 10'h001; // RL11
          end
        end else begin
          d.acc = acc_sum;
        end
      end
      ACQ_MANUAL: begin
        if (!MANUAL_MODE) begin
          d.acq = ACQ_IDLE;
        end else if (man_tick) begin
          d.man_cnt         = '0;
          d.mem[q.man_addr] = peak; // RL8
        end else begin
          d.man_cnt = q.man_cnt + 32'h00000001;
        end
      end
      default: begin
        d.acq = ACQ_IDLE;
      end
    endcase

    // refresh timer and manual point selection
    if (ref_tick) begin
      d.ref_cnt  = '0;
      d.man_addr = (MANUAL_ADDR > LAST_ADDR) ? LAST_ADDR : MANUAL_ADDR; // RL9
    end else begin
      d.ref_cnt = q.ref_cnt + 32'h00000001;
    end

    // display readout, one address per clock
    if (q.rd_active) begin
      d.disp.valid = 1'b1;
      d.disp.addr  = q.rd_addr;
      d.disp.data  = q.mem[q.rd_addr];
      d.disp.over  = q.mem[q.rd_addr] > TOP_LINE_CODE; // RL2
      d.disp.div   = vpt_div(q.mem[q.rd_addr]); // RL3
      if (q.rd_addr == LAST_ADDR) begin // RL10
        d.rd_active = 1'b0;
      end else begin
        d.rd_addr = q.rd_addr + 10'h001;
      end
    end
    if (ref_tick) begin
      d.rd_active = 1'b1; // RL10
      d.rd_addr   = '0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      q     <= '0;
      q.acq <= ACQ_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SWEEP_BUSY = (q.acq == ACQ_SWEEP);
  assign SWEEP_DONE = q.done;
  assign SWEEP_ADDR = q.seg_addr;
  assign DISP       = q.disp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [32:0] gap_cnt;
  always_ff @(posedge CLOCK) begin
    if (RST || start_sweep || seg_tick) begin
      gap_cnt <= '0;
    end else if (gap_cnt != 33'h1FFFFFFFF) begin
      gap_cnt <= gap_cnt + 33'h000000001;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  seg_store_a: assert property ( // RL11
    (seg_tick && !MANUAL_MODE && !SWEEP_START)
      |=> q.mem[$past(q.seg_addr)] == $past(peak))
    else $error("segment peak not stored at its address");
  last_point_a: assert property ( // RL7
    SWEEP_DONE |-> $past(q.seg_addr) == LAST_ADDR && !SWEEP_BUSY)
    else $error("sweep ended before the last address");
  seg_length_a: assert property ( // RL6
    (seg_tick && q.seg_addr != '0 && $stable(SWEEP_TIME_CYCLES))
      |-> (gap_cnt + 33'h000000001) * 33'(SEGS_PER_SPAN) >= span - 33'(SEGS_PER_SPAN))
    else $error("segment shorter than sweep time over 1000");
  man_period_a: assert property ( // RL8
    q.man_cnt < 32'(MANUAL_CYCLES))
    else $error("manual sample period exceeded");
  man_store_a: assert property ( // RL8
    (man_tick && MANUAL_MODE) |=> q.mem[$past(q.man_addr)] == $past(peak))
    else $error("manual sample not stored at the manual point");
  man_addr_a: assert property ( // RL9
    !$stable(q.man_addr) |-> $past(ref_tick))
    else $error("manual point moved outside a refresh");
  scan_end_a: assert property ( // RL10
    (DISP.valid && DISP.addr == LAST_ADDR && !$past(ref_tick, 1)) |=> !DISP.valid)
    else $error("readout ran past the last address");
  scan_start_a: assert property ( // RL10
    ref_tick |=> ##1 DISP.valid && DISP.addr == '0)
    else $error("readout did not start at address 0");
  over_flag_a: assert property ( // RL2 RL3
    DISP.valid |-> DISP.over == (DISP.data > TOP_LINE_CODE)
      && 14'(DISP.div) * 14'(DU_PER_DIV) <= 14'(DISP.data)
      && 14'(DISP.data) < (14'(DISP.div) + 14'h0001) * 14'(DU_PER_DIV))
    else $error("overrange flag or division wrong");

  sweep_done_c:  cover property (SWEEP_DONE);
  man_write_c:   cover property (man_tick);
  scan_done_c:   cover property (DISP.valid && DISP.addr == LAST_ADDR);
  overrange_c:   cover property (DISP.valid && DISP.over);

endmodule : vpt_sampler

// ---- sim/vpt_adc_model.sv ----
`timescale 1ns/10ps
module vpt_adc_model
  import vpt_pkg::*;
(
  input  wire logic              TRACK,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [CODE_W-1:0] LEVEL,
  output vpt_sample_t            SAMPLE
);
  // ----------------------------------------------------------------
  // video ramp rising with sweep position, or a fixed level
  // ----------------------------------------------------------------
  assign SAMPLE = '{valid: 1'b1, code: (TRACK ? ADDR + 10'h017 : LEVEL)};
endmodule : vpt_adc_model

// ---- sim/vpt_sampler_tb.sv ----
`timescale 1ns/10ps
module vpt_sampler_tb;
  import vpt_pkg::*;
  localparam int unsigned MC = 20;
  localparam int unsigned RC = 1100;
  logic              CLOCK, RST, start, manual, track, busy, done;
  logic [31:0]       stime;
  logic [ADDR_W-1:0] maddr, saddr;
  logic [CODE_W-1:0] level;
  vpt_sample_t       sample;
  vpt_disp_t         disp;
  vpt_disp_t         scan [0:1000];
  int                bad_count, total_checks, cyc;

  vpt_adc_model vpt_adc_model_i (.TRACK(track), .ADDR(saddr), .LEVEL(level), .SAMPLE(sample));
  vpt_sampler #(.MANUAL_CYCLES(MC), .REFRESH_CYCLES(RC)) vpt_sampler_i (
    .CLOCK(CLOCK), .RST(RST), .SAMPLE(sample), .SWEEP_START(start),
    .SWEEP_TIME_CYCLES(stime), .MANUAL_MODE(manual), .MANUAL_ADDR(maddr),
    .SWEEP_BUSY(busy), .SWEEP_DONE(done), .SWEEP_ADDR(saddr), .DISP(disp));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk_code(input logic [CODE_W-1:0] got, exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_code

  task automatic chk_flag(input logic got, exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %b", $time, msg, got);
    end
  endtask : chk_flag

  task automatic step(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : step

  task automatic grab_scan;
    int n;
    n = 0;
    while (!(disp.valid === 1'b1 && disp.addr === 10'h000) && n < 3000) begin
      step(1);
      n++;
    end
    for (int k = 0; k <= 1000; k++) begin
      chk_code(disp.addr, ADDR_W'(k), "scan address");
      scan[k] = disp;
      step(1);
    end
    chk_flag(disp.valid, 1'b0, "scan end");
  endtask : grab_scan

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_sweep;
    int n;
    track = 1'b1;
    start = 1'b1;
    step(1);
    start = 1'b0;
    chk_flag(busy, 1'b1, "busy after start");
    chk_code(saddr, 10'h000, "first address");
    n = 1;
    while (done !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    chk_flag(n >= 2000 && n <= 2004, 1'b1, "sweep length");
    chk_flag(done, 1'b1, "sweep done");
    chk_code(saddr, LAST_ADDR, "last address");
    track = 1'b0;
    grab_scan;
    for (int k = 0; k <= 1000; k++) begin
      chk_code(scan[k].data, CODE_W'(k + 23), "segment peak");
      chk_flag(scan[k].over, k + 23 > 1000, "overrange");
      chk_code(CODE_W'(scan[k].div), CODE_W'((k + 23) / 100), "division");
    end
    $display("sweep test done");
  endtask : test_sweep

  task automatic test_manual;
    level = 10'h2BC;
    maddr = 10'h005;
    manual = 1'b1;
    step(1);
    start = 1'b1;
    step(1);
    start = 1'b0;
    chk_flag(busy, 1'b0, "start in manual");
    step(2 * RC);
    level = 10'h12C;
    step(3 * MC);
    grab_scan;
    chk_code(scan[5].data, 10'h12C, "manual point");
    chk_code(scan[0].data, 10'h2BC, "old point");
    chk_code(scan[6].data, 10'h01D, "neighbour");
    manual = 1'b0;
    $display("manual test done");
  endtask : test_manual

  // ----------------------------------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("wrong value at %0t: run timed out", $time);
      stop_test;
    end
  end

  initial begin
    RST = 1'b1;
    start = 1'b0;
    manual = 1'b0;
    track = 1'b0;
    stime = 32'h000007D0;
    maddr = 10'h000;
    level = 10'h000;
    bad_count = 0;
    total_checks = 0;
    cyc = 0;
    step(10);
    RST = 1'b0;
    test_sweep;
    test_manual;
    stop_test;
  end
endmodule : vpt_sampler_tb
